// ===== design/rgbpc_pkg.sv
// Purpose: Shared constants and types for the colour LED parameter unit
// Assumes: 250 MHz system clock, 16-bit register port
// Notes:   Command codes are defaults for the top module's command parameters
package rgbpc_pkg;

    localparam int LVL_W  = 12;
    localparam int OFFT_W = 12;
    localparam int DAT_W  = 16;
    localparam int ADR_W  = 4;
    localparam int CMD_W  = 8;
    localparam int NCH    = 3;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [ADR_W-1:0] CMD_ADDR  = 4'h0;
    localparam logic [ADR_W-1:0] VAL_ADDR  = 4'h1;
    localparam logic [ADR_W-1:0] STAT_ADDR = 4'h2;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and limits
    localparam logic [LVL_W-1:0]  LVL_RST  = 12'h000;
    localparam logic [LVL_W-1:0]  REF_RST  = 12'h000;
    localparam logic [LVL_W-1:0]  REF_MAX  = 12'h080;
    localparam logic [OFFT_W-1:0] OFFT_RST = 12'h040;

    ////////////////////////////////////////////////////////////////////////
    // Off-time tick: 64 MHz derived from the system clock by accumulation
    localparam int CLK_MHZ  = 250;
    localparam int TICK_MHZ = 64;
    localparam logic [8:0] TICK_STEP = 9'(TICK_MHZ);
    localparam logic [8:0] TICK_MOD  = 9'(CLK_MHZ);

    ////////////////////////////////////////////////////////////////////////
    // Pending value counts
    localparam logic [1:0] PEND_NONE = 2'h0;
    localparam logic [1:0] PEND_ONE  = 2'h1;
    localparam logic [1:0] PEND_TWO  = 2'h2;
    localparam logic [1:0] PEND_ALL  = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Default command codes (values arbitrary)
    localparam logic [CMD_W-1:0] DEF_LVL_R  = 8'h01;
    localparam logic [CMD_W-1:0] DEF_LVL_G  = 8'h02;
    localparam logic [CMD_W-1:0] DEF_LVL_B  = 8'h03;
    localparam logic [CMD_W-1:0] DEF_LVL_A  = 8'h04;
    localparam logic [CMD_W-1:0] DEF_REF_R  = 8'h05;
    localparam logic [CMD_W-1:0] DEF_REF_G  = 8'h06;
    localparam logic [CMD_W-1:0] DEF_REF_B  = 8'h07;
    localparam logic [CMD_W-1:0] DEF_OFFT_R = 8'h08;
    localparam logic [CMD_W-1:0] DEF_OFFT_G = 8'h09;
    localparam logic [CMD_W-1:0] DEF_OFFT_B = 8'h0a;

    typedef enum logic [1:0] {
        RGBPC_SW_ON,
        RGBPC_SW_FALL,
        RGBPC_SW_OFF
    } rgbpc_sw_t;

    typedef enum logic [2:0] {
        RGBPC_K_NONE,
        RGBPC_K_LVL,
        RGBPC_K_REF,
        RGBPC_K_OFFT,
        RGBPC_K_ALL
    } rgbpc_kind_t;

endpackage

// ===== design/rgbpc_chan.sv
// Purpose: Peak-current switch control for one colour channel
// Assumes: Comparator input synchronous to clk, tick one cycle at 64 MHz
// Notes:   Switch is on after reset
`timescale 1ns/1ps
module rgbpc_chan
    import rgbpc_pkg::*;
#(
    parameter int OFFT_W_P = OFFT_W
)(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                tick,
    input  wire logic                cmp_hi,
    input  wire logic [OFFT_W_P-1:0] off_time,
    output logic                     sw_on
);

    typedef struct packed {
        rgbpc_sw_t           st;
        logic [OFFT_W_P-1:0] cnt;
        logic                sw;
    } rgbpc_chst_t;

    rgbpc_chst_t s;
    rgbpc_chst_t next_s;

    assign sw_on = s.sw;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        case (s.st)
            RGBPC_SW_ON: begin
                if (cmp_hi) begin
                    next_s.st = RGBPC_SW_FALL;
                    next_s.sw = 1'b0;
                end
            end
            RGBPC_SW_FALL: begin
                // Timer waits for the current to drop below the reference
                if (!cmp_hi) begin
                    next_s.st  = RGBPC_SW_OFF;
                    next_s.cnt = '0;
                end
            end
            RGBPC_SW_OFF: begin
                if (s.cnt >= off_time) begin
                    next_s.st  = RGBPC_SW_ON;
                    next_s.sw  = 1'b1;
                    next_s.cnt = '0;
                end else if (tick) begin
                    next_s.cnt = s.cnt + 1'b1;
                end
            end
            default: begin
                next_s.st = RGBPC_SW_ON;
                next_s.sw = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s.st  <= RGBPC_SW_ON;
            s.cnt <= '0;
            s.sw  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

endmodule

// ===== design/rgbpc_top.sv
// Purpose: Command-driven parameter unit for a three-channel colour driver
// Assumes: Register port synchronous to MCLK, comparators synchronous
// Notes:   Commands go to the command register, values to the value one
// Function
// - Each channel keeps a 12-bit unsigned intensity, 0xfff is maximum.
// - Red, green, blue modulators each follow their stored intensity.
// - Single intensity command plus value replaces only that channel.
// - Combined intensity command takes red, green, blue values in order.
// - Peak-current command plus value updates that channel's reference.
// - Reference code maps linearly: code/4096 of full-scale threshold.
// - Reference above 0x80 is discarded and 0x80 stored instead.
// - Comparator trip drives that channel's switch output low.
// - Switch stays off for the off-time, then turns on again.
// - Off timer starts only after current falls below the reference.
// - Off counter counts at 64 MHz; at off-time it clears, switch on.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module rgbpc_top
    import rgbpc_pkg::*;
#(
    parameter logic [CMD_W-1:0] CMD_LVL_R  = DEF_LVL_R,
    parameter logic [CMD_W-1:0] CMD_LVL_G  = DEF_LVL_G,
    parameter logic [CMD_W-1:0] CMD_LVL_B  = DEF_LVL_B,
    parameter logic [CMD_W-1:0] CMD_LVL_A  = DEF_LVL_A,
    parameter logic [CMD_W-1:0] CMD_REF_R  = DEF_REF_R,
    parameter logic [CMD_W-1:0] CMD_REF_G  = DEF_REF_G,
    parameter logic [CMD_W-1:0] CMD_REF_B  = DEF_REF_B,
    parameter logic [CMD_W-1:0] CMD_OFFT_R = DEF_OFFT_R,
    parameter logic [CMD_W-1:0] CMD_OFFT_G = DEF_OFFT_G,
    parameter logic [CMD_W-1:0] CMD_OFFT_B = DEF_OFFT_B
)(
    input  wire logic              MCLK,
    input  wire logic              RST_N,
    input  wire logic [ADR_W-1:0]  ADDR,
    input  wire logic [DAT_W-1:0]  WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DAT_W-1:0]  RDATA,
    input  wire logic [NCH-1:0]    CMP_HI,
    output logic      [NCH-1:0]    SW_ON,
    output logic      [NCH-1:0]    PDM_OUT,
    output logic      [LVL_W-1:0]  PEAK_REF_R,
    output logic      [LVL_W-1:0]  PEAK_REF_G,
    output logic      [LVL_W-1:0]  PEAK_REF_B
);

    typedef struct packed {
        logic [NCH-1:0][LVL_W-1:0]  lvl;
        logic [NCH-1:0][LVL_W-1:0]  pref;
        logic [NCH-1:0][OFFT_W-1:0] offt;
        logic [1:0][LVL_W-1:0]      hold;
        logic [1:0]                 pend;
        logic [1:0]                 idx;
        rgbpc_kind_t                kind;
        logic [NCH-1:0][LVL_W-1:0]  acc;
        logic [NCH-1:0]             pdm;
        logic [8:0]                 tacc;
        logic                       tick;
        logic [DAT_W-1:0]           rdata;
    } rgbpc_st_t;

    rgbpc_st_t s;
    rgbpc_st_t next_s;

    logic [LVL_W-1:0] val;
    logic [LVL_W:0]   sum [NCH];
    logic [9:0]       tsum;

    assign RDATA      = s.rdata;
    assign PDM_OUT    = s.pdm;
    // Code passed straight to the threshold generator: code/4096 of scale
    assign PEAK_REF_R = s.pref[0];
    assign PEAK_REF_G = s.pref[1];
    assign PEAK_REF_B = s.pref[2];
    assign val        = WDATA[LVL_W-1:0];
    assign tsum       = {1'b0, s.tacc} + {1'b0, TICK_STEP};

    ////////////////////////////////////////////////////////////////////////
    // Peak-current switch control per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign sum[g] = {1'b0, s.acc[g]} + {1'b0, s.lvl[g]};
            rgbpc_chan #(
                .OFFT_W_P (OFFT_W)
            ) rgbpc_chan_inst (
                .clk      (MCLK),
                .rst_n    (RST_N),
                .tick     (s.tick),
                .cmp_hi   (CMP_HI[g]),
                .off_time (s.offt[g]),
                .sw_on    (SW_ON[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Command decode, parameter store, modulators, tick
    always_comb begin
        next_s = s;

        // 64 MHz tick from a fractional accumulator
        if (tsum >= {1'b0, TICK_MOD}) begin
            next_s.tacc = 9'(tsum - {1'b0, TICK_MOD});
            next_s.tick = 1'b1;
        end else begin
            next_s.tacc = tsum[8:0];
            next_s.tick = 1'b0;
        end

        // First-order modulators, duty follows intensity
        for (int i = 0; i < NCH; i++) begin
            next_s.acc[i] = sum[i][LVL_W-1:0];
            next_s.pdm[i] = sum[i][LVL_W];
        end

        if (WR && ADDR == CMD_ADDR) begin
            next_s.pend = PEND_ONE;
            next_s.idx  = 2'd0;
            case (WDATA[CMD_W-1:0])
                CMD_LVL_R: begin
                    next_s.kind = RGBPC_K_LVL;
                    next_s.idx  = 2'd0;
                end
                CMD_LVL_G: begin
                    next_s.kind = RGBPC_K_LVL;
                    next_s.idx  = 2'd1;
                end
                CMD_LVL_B: begin
                    next_s.kind = RGBPC_K_LVL;
                    next_s.idx  = 2'd2;
                end
                CMD_LVL_A: begin
                    next_s.kind = RGBPC_K_ALL;
                    next_s.pend = PEND_ALL;
                end
                CMD_REF_R: begin
                    next_s.kind = RGBPC_K_REF;
                    next_s.idx  = 2'd0;
                end
                CMD_REF_G: begin
                    next_s.kind = RGBPC_K_REF;
                    next_s.idx  = 2'd1;
                end
                CMD_REF_B: begin
                    next_s.kind = RGBPC_K_REF;
                    next_s.idx  = 2'd2;
                end
                CMD_OFFT_R: begin
                    next_s.kind = RGBPC_K_OFFT;
                    next_s.idx  = 2'd0;
                end
                CMD_OFFT_G: begin
                    next_s.kind = RGBPC_K_OFFT;
                    next_s.idx  = 2'd1;
                end
                CMD_OFFT_B: begin
                    next_s.kind = RGBPC_K_OFFT;
                    next_s.idx  = 2'd2;
                end
                default: begin
                    // Unknown code drops any pending command
                    next_s.kind = RGBPC_K_NONE;
                    next_s.pend = PEND_NONE;
                end
            endcase
        end else if (WR && ADDR == VAL_ADDR && s.pend != PEND_NONE) begin
            next_s.pend = s.pend - 1'b1;
            case (s.kind)
                RGBPC_K_LVL: next_s.lvl[s.idx] = val;
                RGBPC_K_REF: begin
                    if (val > REF_MAX) begin
                        next_s.pref[s.idx] = REF_MAX;
                    end else begin
                        next_s.pref[s.idx] = val;
                    end
                end
                RGBPC_K_OFFT: next_s.offt[s.idx] = WDATA[OFFT_W-1:0];
                RGBPC_K_ALL: begin
                    // Red, green, blue; all three change together
                    case (s.pend)
                        PEND_ALL: next_s.hold[0] = val;
                        PEND_TWO: next_s.hold[1] = val;
                        default:  next_s.lvl = {val, s.hold[1], s.hold[0]};
                    endcase
                end
                default: next_s.pend = PEND_NONE;
            endcase
            if (next_s.pend == PEND_NONE) begin
                next_s.kind = RGBPC_K_NONE;
            end
        end

        // Read data valid the cycle after the strobe only
        next_s.rdata = '0;
        if (RD && ADDR == STAT_ADDR) begin
            next_s.rdata = DAT_W'({s.kind, s.pend, SW_ON});
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            s.lvl   <= {NCH{LVL_RST}};
            s.pref  <= {NCH{REF_RST}};
            s.offt  <= {NCH{OFFT_RST}};
            s.hold  <= '0;
            s.pend  <= PEND_NONE;
            s.idx   <= 2'd0;
            s.kind  <= RGBPC_K_NONE;
            s.acc   <= '0;
            s.pdm   <= '0;
            s.tacc  <= '0;
            s.tick  <= 1'b0;
            s.rdata <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

// ===== bench/rgbpc_monitor.sv
// Purpose: Port checks for the colour LED parameter unit
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every rgbpc_top instance
`timescale 1ns/1ps
module rgbpc_monitor
    import rgbpc_pkg::*;
(
    input wire logic             MCLK,
    input wire logic             RST_N,
    input wire logic [ADR_W-1:0] ADDR,
    input wire logic             WR,
    input wire logic             RD,
    input wire logic [DAT_W-1:0] RDATA,
    input wire logic [NCH-1:0]   CMP_HI,
    input wire logic [NCH-1:0]   SW_ON,
    input wire logic [LVL_W-1:0] PEAK_REF_R,
    input wire logic [LVL_W-1:0] PEAK_REF_G,
    input wire logic [LVL_W-1:0] PEAK_REF_B
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    ref_max_a: assert property (
        PEAK_REF_R <= REF_MAX && PEAK_REF_G <= REF_MAX && PEAK_REF_B <= REF_MAX)
        else $error("peak reference above clamp");
    ref_cause_a: assert property (
        $changed({PEAK_REF_R, PEAK_REF_G, PEAK_REF_B}) |-> $past(WR))
        else $error("peak reference moved without a write");
    trip_off_a: assert property (
        (SW_ON & CMP_HI) != 3'h0 |=> (SW_ON & $past(SW_ON & CMP_HI)) == 3'h0)
        else $error("switch stayed on after trip");
    off_hold_a: assert property (
        (~SW_ON & CMP_HI) != 3'h0 |=> (SW_ON & $past(~SW_ON & CMP_HI)) == 3'h0)
        else $error("switch on while current still high");
    no_early_on_a: assert property (
        (SW_ON & ~$past(SW_ON) & $past(CMP_HI)) == 3'h0)
        else $error("switch on straight after comparator high");
    on_bound_a: assert property (
        $fell(CMP_HI[0]) && !SW_ON[0] |-> ##[1:1000] (SW_ON[0] || CMP_HI[0]))
        else $error("red switch never came back on");
    rd_idle_a: assert property (
        !RD |=> RDATA == 16'h0000)
        else $error("read data without read strobe");
    rd_other_a: assert property (
        RD && ADDR != STAT_ADDR |=> RDATA == 16'h0000)
        else $error("non-status read returned data");
endmodule
bind rgbpc_top rgbpc_monitor rgbpc_monitor_inst (.MCLK(MCLK), .RST_N(RST_N),
    .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .CMP_HI(CMP_HI),
    .SW_ON(SW_ON), .PEAK_REF_R(PEAK_REF_R), .PEAK_REF_G(PEAK_REF_G),
    .PEAK_REF_B(PEAK_REF_B));

// ===== bench/rgbpc_host.sv
// Purpose: Host master model on the command register port
// Assumes: Strobes one cycle, changed just after the clock edge
// Notes:   Released lines carry inverted data
`timescale 1ns/1ps
module rgbpc_host
    import rgbpc_pkg::*;
(
    input  wire logic             clk,
    output logic      [ADR_W-1:0] addr,
    output logic      [DAT_W-1:0] wdata,
    output logic                  wr,
    output logic                  rd
);
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end

    task automatic wr_op(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask

    task automatic rd_op(input logic [ADR_W-1:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
    endtask

    task automatic send1(input logic [CMD_W-1:0] c, input logic [11:0] v);
        wr_op(CMD_ADDR, {8'h00, c});
        wr_op(VAL_ADDR, {4'h0, v});
    endtask

    task automatic send3(input logic [CMD_W-1:0] c,
                         input logic [11:0] r, g, b);
        wr_op(CMD_ADDR, {8'h00, c});
        wr_op(VAL_ADDR, {4'h0, r});
        wr_op(VAL_ADDR, {4'h0, g});
        wr_op(VAL_ADDR, {4'h0, b});
    endtask
endmodule

// ===== bench/tb_rgbpc_top.sv
// Purpose: Self-checking bench for the colour LED parameter unit
// Assumes: Host model drives the register port
// Notes:   Each status read pops one expected reference triple
`timescale 1ns/1ps
module tb_rgbpc_top
    import rgbpc_pkg::*;
;
    logic             mclk = 1'b0;
    logic             rst_n;
    logic [ADR_W-1:0] addr;
    logic [DAT_W-1:0] wdata;
    logic             wr;
    logic             rd;
    logic [DAT_W-1:0] rdata;
    logic [NCH-1:0]   cmp_hi;
    logic [NCH-1:0]   sw_on;
    logic [NCH-1:0]   pdm;
    logic [LVL_W-1:0] ref_r;
    logic [LVL_W-1:0] ref_g;
    logic [LVL_W-1:0] ref_b;
    logic [35:0]      exp_q[$];
    logic [11:0]      rf [3];
    logic [11:0]      lv [3];
    logic             rd_d;
    int               num_errors = 0;
    int               checked = 0;
    int               n;
    localparam logic [DAT_W-1:0] STAT_IDLE =
        {8'h00, RGBPC_K_NONE, PEND_NONE, 3'h7};

    always #2 mclk = ~mclk;

    rgbpc_top rgbpc_top_inst (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CMP_HI(cmp_hi),
        .SW_ON(sw_on), .PDM_OUT(pdm), .PEAK_REF_R(ref_r),
        .PEAK_REF_G(ref_g), .PEAK_REF_B(ref_b));
    rgbpc_host rgbpc_host_inst (.clk(mclk), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Errors %0d in %0d checks", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scoreboard: compares at the cycle the status data stands
    always @(posedge mclk) begin
        rd_d <= rd && addr == STAT_ADDR;
        if (rd_d === 1'b1) begin
            check(36'(rdata), 36'(STAT_IDLE));
            check(36'({ref_r, ref_g, ref_b}), exp_q.pop_front());
        end
    end

    task automatic stat();
        exp_q.push_back(36'({rf[0], rf[1], rf[2]}));
        rgbpc_host_inst.rd_op(STAT_ADDR);
    endtask

    task automatic set_ref(input int c, input logic [11:0] v);
        rgbpc_host_inst.send1(CMD_W'(DEF_REF_R + c), v);
        rf[c] = (v > REF_MAX) ? REF_MAX : v;
        stat();
    endtask

    task automatic meas();
        int cnt [3];
        cnt = '{0, 0, 0};
        repeat (1024) begin
            @(posedge mclk);
            for (int i = 0; i < 3; i++) cnt[i] += int'(pdm[i]);
        end
        for (int i = 0; i < 3; i++) begin
            n = cnt[i] - int'(lv[i]) / 4;
            check(36'(n >= -3 && n <= 3), 36'h1);
        end
    endtask

    task automatic off_case(input int c, input logic [11:0] v);
        rgbpc_host_inst.send1(CMD_W'(DEF_OFFT_R + c), v);
        @(posedge mclk);
        cmp_hi <= NCH'(1 << c);
        repeat (3) @(posedge mclk);
        check(36'(sw_on[c]), 36'h0);
        cmp_hi <= 3'h0;
        n = 0;
        while (sw_on[c] !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        n = n - int'(v) * CLK_MHZ / TICK_MHZ;
        check(36'(n >= -2 && n <= 8), 36'h1);
        repeat (300) @(posedge mclk);
        check(36'(sw_on), 36'h7);
    endtask

    initial begin
        rst_n = 1'b0;
        cmp_hi = 3'h0;
        n = $urandom(32'h20ed);
        rf = '{3{12'h000}};
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rf[c]) begin
            set_ref(c, 12'h064);
            set_ref(c, 12'h081);
            set_ref(c, 12'h080);
            set_ref(c, 12'($urandom()));
        end
        // Unknown code drops a pending command; stray writes move nothing
        rgbpc_host_inst.wr_op(CMD_ADDR, 16'(DEF_REF_R));
        rgbpc_host_inst.send1(8'hff, 12'h010);
        rgbpc_host_inst.wr_op(VAL_ADDR, 16'h0010);
        rgbpc_host_inst.wr_op(4'h5, 16'h0003);
        rgbpc_host_inst.rd_op(4'h9);
        stat();
        foreach (lv[i]) lv[i] = 12'($urandom());
        rgbpc_host_inst.send3(DEF_LVL_A, lv[0], lv[1], lv[2]);
        meas();
        lv = '{12'h800, 12'h800, 12'h000};
        rgbpc_host_inst.send3(DEF_LVL_A, lv[0], lv[1], lv[2]);
        meas();
        lv[1] = 12'hfff;
        rgbpc_host_inst.send1(DEF_LVL_G, 12'hfff);
        meas();
        lv[0] = 12'h123;
        lv[2] = 12'h456;
        rgbpc_host_inst.send1(DEF_LVL_R, lv[0]);
        rgbpc_host_inst.send1(DEF_LVL_B, lv[2]);
        meas();
        off_case(0, 12'h000);
        off_case(1, 12'h010);
        off_case(2, 12'h040);
        off_case(0, 12'h040);
        summarize();
    end

    initial begin
        #100000;
        num_errors++;
        summarize();
    end
endmodule
